// File: rtl/ofjac_fuse_access.sv
// Test-port access to fuse registers with lock and policy decode
`timescale 1ns/1ps
`include "ofjac_map.svh"
module ofjac_fuse_access
   import ofjac_pkg::*;
#(
   parameter int CTRL_WIDTH = `OFJAC_LEN_LOCK_CTRL,
   // Identifier value is arbitrary, set per part at build time
   parameter logic [95:0] DEVICE_ID = 96'h5A5A_0000_0000_0000_0000_A5A5
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Instruction code, decoded here, and test-port controller strobes, already decoded
   input wire logic [5:0] instr_in,
   input ofjac_tap_s tap_in,
   input wire logic program_in,
   // Configuration engine busy, programming is held off
   input wire logic config_busy_in,
   // Serial data out
   output logic tdo_out,
   // Refused access flags (sticky until next capture)
   output logic read_refused_out,
   output logic write_refused_out,
   // Fabric-side user code
   output logic [31:0] fabric_user_code_port_out,
   // Policy to the configuration logic
   output ofjac_policy_s policy_out,
   output logic [CTRL_WIDTH-1:0] lock_control_out,
   output logic [31:0] security_policy_out
);

   ////////////////////////////////////////////////////////////////////
   // Selection and fuse banks
   ofjac_sel_e sel;
   logic [`OFJAC_DR_MAX-1:0] dr;
   logic [`OFJAC_DR_MAX-1:0] captured;
   logic [383:0] auth_q;
   logic [255:0] key_q;
   logic [31:0] u32_q;
   logic [127:0] u128_q;
   logic [CTRL_WIDTH-1:0] ctrl_q;
   logic [31:0] sec_q;
   logic burn_auth, burn_key, burn_u32, burn_u128, burn_ctrl, burn_sec;
   logic read_ok, write_ok, burn_any;

   ofjac_decode u_decode (
      .instr_in(instr_in),
      .sel_out(sel)
   );

   // Width of the selected data register
   function automatic int unsigned dr_len(input ofjac_sel_e s);
      case (s)
         OFJAC_SEL_AUTH: dr_len = `OFJAC_LEN_AUTH_HASH;
         OFJAC_SEL_KEY: dr_len = `OFJAC_LEN_ENC_KEY;
         OFJAC_SEL_ID: dr_len = `OFJAC_LEN_DEVICE_ID;
         OFJAC_SEL_U32: dr_len = `OFJAC_LEN_USER32;
         OFJAC_SEL_U128: dr_len = `OFJAC_LEN_USER128;
         OFJAC_SEL_CTRL: dr_len = CTRL_WIDTH;
         OFJAC_SEL_SEC: dr_len = `OFJAC_LEN_POLICY;
         default: dr_len = 1;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Read and write permission
   // read locks
   always_comb
   begin
      read_ok = 1'b1;
      if (sel == OFJAC_SEL_NONE)
         read_ok = 1'b0;
      else if (sel == OFJAC_SEL_U32)
         read_ok = !ctrl_q[`OFJAC_CB_USER32_RLOCK];
      else if (sel == OFJAC_SEL_SEC)
         read_ok = !ctrl_q[`OFJAC_CB_POLICY_RLOCK];
      else if (sel == OFJAC_SEL_AUTH)
         read_ok = !ctrl_q[`OFJAC_CB_AUTH_RLOCK];
   end

   always_comb
   begin
      write_ok = 1'b0;
      case (sel)
         OFJAC_SEL_AUTH: write_ok = !ctrl_q[`OFJAC_CB_AUTH_WLOCK];
         OFJAC_SEL_KEY: write_ok = !ctrl_q[`OFJAC_CB_KEY_WLOCK];
         OFJAC_SEL_U32: write_ok = !ctrl_q[`OFJAC_CB_USER32_WLOCK];
         OFJAC_SEL_U128: write_ok = !ctrl_q[`OFJAC_CB_USER128_WLOCK];
         OFJAC_SEL_CTRL: write_ok = !ctrl_q[`OFJAC_CB_CTRL_WLOCK];
         OFJAC_SEL_SEC: write_ok = !ctrl_q[`OFJAC_CB_POLICY_WLOCK];
         default: write_ok = 1'b0;
      endcase
   end

   // burn only on update with program set and no lock
   assign burn_any = tap_in.update && program_in && write_ok &&
      !config_busy_in;
   assign burn_auth = burn_any && (sel == OFJAC_SEL_AUTH);
   assign burn_key = burn_any && (sel == OFJAC_SEL_KEY);
   assign burn_u32 = burn_any && (sel == OFJAC_SEL_U32);
   assign burn_u128 = burn_any && (sel == OFJAC_SEL_U128);
   assign burn_ctrl = burn_any && (sel == OFJAC_SEL_CTRL);
   assign burn_sec = burn_any && (sel == OFJAC_SEL_SEC);

   ////////////////////////////////////////////////////////////////////
   // Fuse banks
   // one-way fuse storage
   ofjac_fuse_bank #(.WIDTH(384)) u_auth (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .burn_in(burn_auth),
      .pattern_in(dr[383:0]), .fuses_out(auth_q));
   ofjac_fuse_bank #(.WIDTH(256)) u_key (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .burn_in(burn_key),
      .pattern_in(dr[255:0]), .fuses_out(key_q));
   ofjac_fuse_bank #(.WIDTH(32)) u_u32 (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .burn_in(burn_u32),
      .pattern_in(dr[31:0]), .fuses_out(u32_q));
   ofjac_fuse_bank #(.WIDTH(128)) u_u128 (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .burn_in(burn_u128),
      .pattern_in(dr[127:0]), .fuses_out(u128_q));
   ofjac_fuse_bank #(.WIDTH(CTRL_WIDTH)) u_ctrl (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .burn_in(burn_ctrl),
      .pattern_in(dr[CTRL_WIDTH-1:0] &
         CTRL_WIDTH'(`OFJAC_CTRL_USED_MASK)),
      .fuses_out(ctrl_q));
   ofjac_fuse_bank #(.WIDTH(32)) u_sec (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .burn_in(burn_sec),
      .pattern_in(dr[31:0] & `OFJAC_SEC_USED_MASK),
      .fuses_out(sec_q));

   ////////////////////////////////////////////////////////////////////
   // Capture value of the selected register
   always_comb
   begin
      captured = '0;
      if (read_ok)
      begin
         case (sel)
            OFJAC_SEL_AUTH: captured[383:0] = auth_q;
            OFJAC_SEL_KEY: captured[255:0] = key_q;
            OFJAC_SEL_ID: captured[95:0] = DEVICE_ID;
            OFJAC_SEL_U32: captured[31:0] = u32_q;
            OFJAC_SEL_U128: captured[127:0] = u128_q;
            OFJAC_SEL_CTRL: captured[CTRL_WIDTH-1:0] = ctrl_q;
            OFJAC_SEL_SEC: captured[31:0] = sec_q;
            default: captured = '0;
         endcase
      end
   end

   // shift toward bit 0, tdi enters at the register's top bit
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         dr <= '0;
      else if (tap_in.capture)
         dr <= captured;
      else if (tap_in.shift)
      begin
         dr <= dr >> 1;
         dr[dr_len(sel)-1] <= tap_in.tdi;
      end
   end

   // Serial out from a flop, bit 0 first; capture shows bit 0 at once
   // so a shift straight after capture does not lose it
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         tdo_out <= 1'b0;
      else if (tap_in.capture)
         tdo_out <= captured[0];
      else
         tdo_out <= tap_in.shift ? dr[1] : dr[0];
   end

   // Refusal flags, set wins over the capture clear
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         read_refused_out <= 1'b0;
         write_refused_out <= 1'b0;
      end
      else
      begin
         if (tap_in.capture)
            read_refused_out <= !read_ok;
         if (tap_in.update && program_in && !burn_any)
            write_refused_out <= 1'b1;
         else if (tap_in.capture)
            write_refused_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Policy outputs
   // fabric port ignores the read lock
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         fabric_user_code_port_out <= '0;
      else
         fabric_user_code_port_out <= u32_q;
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         policy_out <= '0;
      else
      begin
         policy_out.key_crc_check_off <= ctrl_q[`OFJAC_CB_KEY_CRC_OFF] |
            ctrl_q[`OFJAC_CB_KEY_WLOCK];
         policy_out.encrypted_only <= sec_q[`OFJAC_SB_ENC_ONLY];
         policy_out.force_fuse_key <= sec_q[`OFJAC_SB_FUSE_KEY];
         policy_out.force_authentication <= sec_q[`OFJAC_SB_FORCE_AUTH];
         policy_out.test_pins_off <= sec_q[`OFJAC_SB_PINS_OFF];
         policy_out.scan_off <= sec_q[`OFJAC_SB_SCAN_OFF];
         policy_out.decryptor_off <= sec_q[`OFJAC_SB_DECRYPT_OFF];
         policy_out.key_obfuscation_on <= sec_q[`OFJAC_SB_OBFUSCATE];
      end
   end

   // Raw register images for the configuration logic
   assign lock_control_out = ctrl_q;
   assign security_policy_out = sec_q;

   ////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_locked_prog(int b, ofjac_sel_e s);
      tap_in.update && program_in && ctrl_q[b] && sel == s;
   endsequence

   AST_CTRL_WLOCK: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      s_locked_prog(`OFJAC_CB_CTRL_WLOCK, OFJAC_SEL_CTRL) |=>
      $stable(ctrl_q))
      else $error("locked control register changed");
   AST_KEY_WLOCK: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      s_locked_prog(`OFJAC_CB_KEY_WLOCK, OFJAC_SEL_KEY) |=> $stable(key_q))
      else $error("locked key changed");
   AST_U32_WLOCK: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      s_locked_prog(`OFJAC_CB_USER32_WLOCK, OFJAC_SEL_U32) |=>
      $stable(u32_q))
      else $error("locked user32 changed");
   AST_SEC_WLOCK: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      s_locked_prog(`OFJAC_CB_POLICY_WLOCK, OFJAC_SEL_SEC) |=>
      $stable(sec_q))
      else $error("locked policy changed");
   AST_AUTH_WLOCK: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      s_locked_prog(`OFJAC_CB_AUTH_WLOCK, OFJAC_SEL_AUTH) |=>
      $stable(auth_q))
      else $error("locked auth hash changed");
   AST_U32_RLOCK: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      tap_in.capture && sel == OFJAC_SEL_U32 &&
      ctrl_q[`OFJAC_CB_USER32_RLOCK] |=> dr == '0 && read_refused_out)
      else $error("user32 read not blocked");
   AST_SEC_RLOCK: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      tap_in.capture && sel == OFJAC_SEL_SEC &&
      ctrl_q[`OFJAC_CB_POLICY_RLOCK] |=> dr == '0)
      else $error("policy read not blocked");
   AST_PINS_OFF: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      sec_q[`OFJAC_SB_PINS_OFF] |=> policy_out.test_pins_off)
      else $error("test pins not disabled");
   AST_CRC_OFF: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      ctrl_q[`OFJAC_CB_KEY_CRC_OFF] |=> policy_out.key_crc_check_off)
      else $error("key crc check not skipped");
   AST_BUSY_NO_BURN: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      config_busy_in && tap_in.update && program_in |=>
      $stable(ctrl_q) && $stable(sec_q) && $stable(key_q) &&
      $stable(auth_q) && write_refused_out)
      else $error("burn during configuration");
endmodule // ofjac_fuse_access

// File: inc/ofjac_map.svh
// Instruction codes, bit positions and sizes of the fuse access block
`ifndef OFJAC_MAP_SVH
`define OFJAC_MAP_SVH
`define OFJAC_IR_AUTH_HASH 6'h18
`define OFJAC_IR_ENC_KEY 6'h31
`define OFJAC_IR_DEVICE_ID 6'h32
`define OFJAC_IR_USER32 6'h33
`define OFJAC_IR_USER128 6'h19
`define OFJAC_IR_LOCK_CTRL 6'h34
`define OFJAC_IR_POLICY 6'h3B
`define OFJAC_CB_KEY_CRC_OFF 0
`define OFJAC_CB_USER32_RLOCK 1
`define OFJAC_CB_POLICY_RLOCK 2
`define OFJAC_CB_CTRL_WLOCK 5
`define OFJAC_CB_AUTH_RLOCK 6
`define OFJAC_CB_KEY_WLOCK 7
`define OFJAC_CB_USER32_WLOCK 8
`define OFJAC_CB_POLICY_WLOCK 9
`define OFJAC_CB_AUTH_WLOCK 15
`define OFJAC_CB_USER128_WLOCK 16
`define OFJAC_CTRL_USED_MASK 24'h0183E7
`define OFJAC_SB_ENC_ONLY 0
`define OFJAC_SB_FUSE_KEY 1
`define OFJAC_SB_FORCE_AUTH 2
`define OFJAC_SB_PINS_OFF 3
`define OFJAC_SB_SCAN_OFF 4
`define OFJAC_SB_DECRYPT_OFF 5
`define OFJAC_SB_OBFUSCATE 6
`define OFJAC_SEC_USED_MASK 32'h0000007F
`define OFJAC_LEN_AUTH_HASH 384
`define OFJAC_LEN_ENC_KEY 256
`define OFJAC_LEN_DEVICE_ID 96
`define OFJAC_LEN_USER32 32
`define OFJAC_LEN_USER128 128
`define OFJAC_LEN_LOCK_CTRL 24
`define OFJAC_LEN_POLICY 32
`define OFJAC_DR_MAX 384
`define OFJAC_IR_LEN 6
`endif

// File: inc/ofjac_pkg.sv
// Types shared by the fuse access block
package ofjac_pkg;
   typedef enum logic [2:0] {
      OFJAC_SEL_NONE,
      OFJAC_SEL_AUTH,
      OFJAC_SEL_KEY,
      OFJAC_SEL_ID,
      OFJAC_SEL_U32,
      OFJAC_SEL_U128,
      OFJAC_SEL_CTRL,
      OFJAC_SEL_SEC
   } ofjac_sel_e;
   // Test-port signals sampled on clk_in
   typedef struct packed {
      logic capture;
      logic shift;
      logic update;
      logic tdi;
   } ofjac_tap_s;
   // Decoded policy outputs
   typedef struct packed {
      logic key_crc_check_off;
      logic encrypted_only;
      logic force_fuse_key;
      logic force_authentication;
      logic test_pins_off;
      logic scan_off;
      logic decryptor_off;
      logic key_obfuscation_on;
   } ofjac_policy_s;
endpackage

// File: rtl/ofjac_decode.sv
// Instruction decoder for the fuse access block
`timescale 1ns/1ps
`include "ofjac_map.svh"
module ofjac_decode
   import ofjac_pkg::*;
(
   // Instruction in
   input wire logic [5:0] instr_in,
   // Selection out
   output ofjac_sel_e sel_out
);
   // Map instruction to fuse register
   always_comb
   begin
      if (instr_in == `OFJAC_IR_AUTH_HASH)
         sel_out = OFJAC_SEL_AUTH;
      else if (instr_in == `OFJAC_IR_ENC_KEY)
         sel_out = OFJAC_SEL_KEY;
      else if (instr_in == `OFJAC_IR_DEVICE_ID)
         sel_out = OFJAC_SEL_ID;
      else if (instr_in == `OFJAC_IR_USER32)
         sel_out = OFJAC_SEL_U32;
      else if (instr_in == `OFJAC_IR_USER128)
         sel_out = OFJAC_SEL_U128;
      else if (instr_in == `OFJAC_IR_LOCK_CTRL)
         sel_out = OFJAC_SEL_CTRL;
      else if (instr_in == `OFJAC_IR_POLICY)
         sel_out = OFJAC_SEL_SEC;
      else
         sel_out = OFJAC_SEL_NONE;
   end
endmodule // ofjac_decode

// File: rtl/ofjac_fuse_bank.sv
// One bank of one-time-programmable fuse bits
`timescale 1ns/1ps
module ofjac_fuse_bank #(
   parameter int WIDTH = 32
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Programming request
   input wire logic burn_in,
   input wire logic [WIDTH-1:0] pattern_in,
   // Fuse state, programmed bits read one
   output logic [WIDTH-1:0] fuses_out
);
   // Bits only ever go from zero to one; reset stands in for the
   // sensed array, which a real part would load at power-up
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         fuses_out <= '0;
      else if (burn_in)
         fuses_out <= fuses_out | pattern_in;
   end

   AST_FUSE_NEVER_CLEARS: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      ($past(fuses_out) & ~fuses_out) == '0)
      else $error("a fuse bit went back to zero");
endmodule // ofjac_fuse_bank

// File: bench/ofjac_host_model.sv
// Test-port host model that scans fuse data registers
`timescale 1ns/1ps
module ofjac_host_model
   import ofjac_pkg::*;
(
   // Clock and serial return
   input wire logic clk_in,
   input wire logic tdo_in,
   // Test-port requests
   output logic [5:0] instr_out,
   output ofjac_tap_s tap_out,
   output logic program_out
);
   ////////////////////////////////////////////////////////////////////
   // Idle values at time zero
   initial
   begin
      instr_out = 6'h00;
      tap_out = '0;
      program_out = 1'h0;
   end
   ////////////////////////////////////////////////////////////////////
   // One data scan: capture, len shifts, then update
   // Drives only on the falling edge so the block samples settled values
   // test-port scan, LSB first
   task automatic scan(input logic [5:0] ir, input int len,
      input logic [383:0] din, input logic prog,
      output logic [383:0] dout);
      dout = '0;
      @(negedge clk_in);
      instr_out = ir;
      tap_out.capture = 1'h1;
      for (int i = 0; i < len; i++)
      begin
         @(negedge clk_in);
         dout[i] = tdo_in;
         tap_out.capture = 1'h0;
         tap_out.shift = 1'h1;
         tap_out.tdi = din[i];
      end
      @(negedge clk_in);
      tap_out.shift = 1'h0;
      // Stale data bit inverted so it is never mistaken for data
      tap_out.tdi = ~tap_out.tdi;
      tap_out.update = 1'h1;
      program_out = prog;
      @(negedge clk_in);
      tap_out.update = 1'h0;
      program_out = 1'h0;
   endtask
endmodule // ofjac_host_model

// File: bench/otp_fuse_jtag_access_control_test.sv
// Self-checking bench for the fuse access block
`timescale 1ns/1ps
module otp_fuse_jtag_access_control_test
   import ofjac_pkg::*;
;
   typedef struct {
      logic [5:0] ir;
      int len;
      logic [383:0] din;
      logic prog;
      logic [383:0] exp;
      logic rref;
      logic wref;
   } ofjac_row_s;
   // Arbitrary identifier value
   localparam logic [95:0] dev_id = 96'h0123_4567_89AB_CDEF_0F1E_2D3C;
   localparam logic hi = 1'h1;
   localparam logic lo = 1'h0;
   logic clk_in = 1'h0;
   logic rst_n_in = 1'h0;
   logic busy = 1'h0;
   logic [5:0] instr;
   ofjac_tap_s tap;
   logic prog, tdo, rref, wref;
   logic [31:0] fab, sec;
   logic [23:0] ctrl;
   ofjac_policy_s pol;
   logic [383:0] got;
   int errors = 0;
   int checked = 0;
   ////////////////////////////////////////////////////////////////////
   // Scans in order; fuses accumulate, so row order matters
   ofjac_row_s rows [25] = '{
      '{6'h33, 32, 32'hA5C3_0F01, hi, '0, lo, lo},
      '{6'h33, 32, '0, lo, 32'hA5C3_0F01, lo, lo},
      '{6'h3B, 32, 32'hFFFF_FFD5, hi, '0, lo, lo},
      '{6'h3B, 32, '0, lo, 32'h0000_0055, lo, lo},
      '{6'h18, 384, 16'h1234, hi, '0, lo, lo},
      '{6'h18, 384, '0, lo, 16'h1234, lo, lo},
      '{6'h19, 128, 16'hBEEF, hi, '0, lo, lo},
      '{6'h19, 128, '0, lo, 16'hBEEF, lo, lo},
      '{6'h31, 256, 8'h77, hi, '0, lo, lo},
      '{6'h31, 256, '0, lo, 8'h77, lo, lo},
      '{6'h32, 96, 8'h01, hi, dev_id, lo, hi},
      '{6'h32, 96, '0, lo, dev_id, lo, lo},
      '{6'h00, 8, '0, lo, '0, hi, lo},
      '{6'h34, 24, 24'hFF_FFFE, hi, '0, lo, lo},
      '{6'h34, 24, '0, lo, 24'h01_83E6, lo, lo},
      '{6'h33, 32, '0, lo, '0, hi, lo},
      '{6'h33, 32, 16'hFFFF, hi, '0, hi, hi},
      '{6'h3B, 32, 8'h02, hi, '0, hi, hi},
      '{6'h18, 384, 8'hFF, hi, '0, hi, hi},
      '{6'h31, 256, 8'hFF, hi, 8'h77, lo, hi},
      '{6'h31, 256, '0, lo, 8'h77, lo, lo},
      '{6'h19, 128, 16'hFF00, hi, 16'hBEEF, lo, hi},
      '{6'h19, 128, '0, lo, 16'hBEEF, lo, lo},
      '{6'h34, 24, 8'h01, hi, 24'h01_83E6, lo, hi},
      '{6'h34, 24, '0, lo, 24'h01_83E6, lo, lo}
   };
   ////////////////////////////////////////////////////////////////////
   // Clock, design and host
   always #12.5 clk_in = ~clk_in;
   ofjac_fuse_access #(.CTRL_WIDTH(24), .DEVICE_ID(dev_id)) dut (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .instr_in(instr),
      .tap_in(tap), .program_in(prog), .config_busy_in(busy),
      .tdo_out(tdo), .read_refused_out(rref), .write_refused_out(wref),
      .fabric_user_code_port_out(fab), .policy_out(pol),
      .lock_control_out(ctrl), .security_policy_out(sec));
   ofjac_host_model host (.clk_in(clk_in), .tdo_in(tdo),
      .instr_out(instr), .tap_out(tap), .program_out(prog));
   ////////////////////////////////////////////////////////////////////
   // Compare and report
   task automatic check(input string name, input logic [383:0] seen,
      input logic [383:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   // Watchdog: the scans need about 86 us, so 1 ms means a hang
   initial
   begin
      #1000000;
      errors++;
      $display("ERROR watchdog expected finish seen hang");
      conclude();
   end
   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (3) @(negedge clk_in);
      rst_n_in = 1'h1;
      // busy held low: host never burns during configuration
      foreach (rows[k])
      begin
         host.scan(rows[k].ir, rows[k].len, rows[k].din, rows[k].prog, got);
         repeat (2) @(negedge clk_in);
         check("scan data", got, rows[k].exp);
         check("read refused", rref, rows[k].rref);
         check("write refused", wref, rows[k].wref);
      end
      check("fabric user code", fab, 32'hA5C3_0F01);
      check("security raw", sec, 32'h0000_0055);
      check("control raw", ctrl, 24'h01_83E6);
      check("policy decode", pol, 8'hD5);
      // Reset stands in for a fresh part
      rst_n_in = 1'h0;
      repeat (3) @(negedge clk_in);
      check("reset outputs", {ctrl, sec, fab, pol, rref, wref}, '0);
      rst_n_in = 1'h1;
      // Burn attempt during configuration must be refused
      busy = 1'h1;
      host.scan(6'h34, 24, 8'h01, hi, got);
      repeat (2) @(negedge clk_in);
      check("busy refused", wref, hi);
      check("busy no burn", ctrl, 24'h00_0000);
      busy = 1'h0;
      host.scan(6'h34, 24, 8'h01, hi, got);
      repeat (2) @(negedge clk_in);
      check("crc skip control", ctrl, 24'h00_0001);
      check("crc skip decode", pol, 8'h80);
      // Policy bits not reached by the rows: fuse key, pins, decryptor
      host.scan(6'h3B, 32, 8'h2A, hi, got);
      repeat (2) @(negedge clk_in);
      check("policy second burn", sec, 32'h0000_002A);
      check("policy second decode", pol, 8'hAA);
      conclude();
   end
endmodule // otp_fuse_jtag_access_control_test
